/* File: design/fuser_pkg.sv */
// Constants, register map and conversion helpers for the fuser heater control block.
// Assumes sense inputs are 12-bit millivolt codes from an external converter, synchronous to pclk.
// Function
// - Controller fails the fuser when main sense is at or below 0.9V or sub at or above 0.46V.
// - On controller failure, drop heater drive first, then stop the relay enable request.
// - After the relay request stops, safety drops main relay drive, then sub relay drive.
// - Safety circuit fails alone at main sense 0.8V or lower, or sub 0.41V or higher.
// - On its own failure, safety drops main relay drive first and sub relay drive second.
// - If sub reads below 50C at power-on, heat for a preset time before the motor starts.
// - Start-up heater power is picked from the sub reading at heater energisation.
// - Energised within 30 s of the last print, start-up control begins from current temperature.
// - Target rises step by step within a print and is adjusted by continuous print count.
// - Target temperature and engine speed come from the media type.
// - Between sheets the heater is held below the print target, by gap and media.
// - In standby the fuser is held near 76.7C for a fast first print.
// - Heater drive follows the sensed voltage so the heater settles at the current target.
// - Loss of the interlocked supply means the front cover is open, and is reported.
// - A sleep command stops the 24V and 5V supplies and asserts the power-save request.
// - A command ending sleep returns the controller to the wait period.
// - The low-mains input selects the 100V or 200V control parameter set.
package fuser_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] AUTO_TARGET_OFS = 8'h04;
  localparam logic [7:0] GAP_DROP_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] INT_STATUS_OFS = 8'h10;
  localparam logic [7:0] INT_MASK_OFS = 8'h14;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MEDIA_LSB = 1;
  localparam int MEDIA_W = 5;
  localparam logic [11:0] AUTO_TARGET_RST = 12'h76c;
  localparam logic [7:0] GAP_DROP_RST = 8'h64;
  localparam int INT_W = 5;
  localparam int INT_CTRL_FAIL = 0;
  localparam int INT_SAFETY_FAIL = 1;
  localparam int INT_COVER_OPEN = 2;
  localparam int INT_SLEEP = 3;
  localparam int INT_WAKE = 4;
  localparam logic [11:0] CTRL_MAIN_FAIL_MV = 12'h384;
  localparam logic [11:0] CTRL_SUB_FAIL_MV = 12'h1cc;
  localparam logic [11:0] SAFE_MAIN_FAIL_MV = 12'h320;
  localparam logic [11:0] SAFE_SUB_FAIL_MV = 12'h19a;
  localparam int MAIN_MV_AT_ZERO = 3000;
  localparam int MAIN_MV_PER_KT10 = 913;
  localparam int SUB_MV_PER_KT10 = 161;
  localparam logic [11:0] STANDBY_T10 = 12'h2ff;
  localparam logic [11:0] COLD_SUB_T10 = 12'h1f4;
  localparam logic [11:0] COLD_START_T10 = 12'h0fa;
  localparam logic [11:0] WARM_SUB_T10 = 12'h3e8;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int WARM_WINDOW_S = 30;
  localparam int WARM_WINDOW_MS = WARM_WINDOW_S * 1000;
  localparam int INIT_HEAT_MS = 2000;
  localparam int STEP_MS = 500;
  localparam logic [7:0] STEP_T10 = 8'h0a;
  localparam logic [7:0] STEP_MAX_T10 = 8'h32;
  localparam logic [5:0] COUNT_MAX = 6'h28;
  localparam logic [11:0] RAMP_MV_PER_MS = 12'h002;
  localparam logic [11:0] HYST_100_MV = 12'h014;
  localparam logic [11:0] HYST_200_MV = 12'h00a;
  localparam logic [4:0] DUTY_FULL = 5'h10;
  localparam logic [4:0] DUTY_200_CAP = 5'h0c;
  localparam logic [4:0] DUTY_WARM = 5'h08;
  localparam logic [1:0] SPEED_AUTO = 2'h0;
  localparam logic [1:0] SPEED_FULL = 2'h1;
  localparam logic [1:0] SPEED_HALF = 2'h2;
  localparam logic [1:0] SPEED_THIRD = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT_HEAT, ST_STARTUP, ST_STANDBY, ST_PRINT, ST_SLEEP, ST_FAIL
  } fuser_state_t;

  function automatic logic [11:0] main_mv_of(input logic [11:0] t10);
    int v;
    v = MAIN_MV_AT_ZERO - (int'(t10) * MAIN_MV_PER_KT10) / 1000;
    if (v < 0) begin
      v = 0;
    end
    return v[11:0];
  endfunction

  function automatic logic [11:0] sub_mv_of(input logic [11:0] t10);
    int v;
    v = (int'(t10) * SUB_MV_PER_KT10) / 1000;
    return v[11:0];
  endfunction
endpackage

/* File: design/ms_tick.sv */
// Millisecond tick generator used to pace every slow timer of the fuser block.
// Assumes a free-running pclk; the period is a parameter so a bench can shorten it.
`timescale 1ns/100ps
module ms_tick #(
  parameter int CYCLES = fuser_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  import fuser_pkg::*;
  logic [31:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

/* File: design/relay_safety.sv */
// Independent heater safety circuit driving the two heater relays.
// Assumes the sense codes are already synchronous; it never depends on the controller to trip.
`timescale 1ns/100ps
module relay_safety (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] main_temp_sense,
  input wire logic [11:0] sub_temp_sense,
  input wire logic relay_enable_request,
  output logic main_relay_drive,
  output logic sub_relay_drive,
  output logic safety_fail
);
  import fuser_pkg::*;
  logic trip;

  // Main threshold sits beyond the controller one, but the sub one (0.41V) is below the controller's 0.46V, so a rising sub reading trips this first.
  assign trip = (main_temp_sense <= SAFE_MAIN_FAIL_MV) || (sub_temp_sense >= SAFE_SUB_FAIL_MV);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_fail <= 1'b0;
    end else if (trip) begin
      safety_fail <= 1'b1;
    end
  end

  // Main opens in the first cycle, sub one cycle later; closing takes the reverse order.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_relay_drive <= 1'b0;
      sub_relay_drive <= 1'b0;
    end else if (!relay_enable_request || safety_fail || trip) begin
      main_relay_drive <= 1'b0;
      sub_relay_drive <= main_relay_drive ? sub_relay_drive : 1'b0;
    end else begin
      sub_relay_drive <= 1'b1;
      main_relay_drive <= sub_relay_drive;
    end
  end
endmodule

/* File: design/fuser_ctrl.sv */
// Fuser heater temperature controller with APB registers, sequencing, sleep and protection.
// Assumes sense inputs and formatter commands are synchronous to pclk and command pulses last one cycle.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module fuser_ctrl #(
  parameter int TICK_CYCLES = fuser_pkg::TICK_CYCLES,
  parameter int WARM_WINDOW_MS = fuser_pkg::WARM_WINDOW_MS,
  parameter int INIT_HEAT_MS = fuser_pkg::INIT_HEAT_MS,
  parameter int STEP_MS = fuser_pkg::STEP_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fuser_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] main_temp_sense,
  input wire logic [11:0] sub_temp_sense,
  input wire logic low_mains_detect,
  input wire logic interlocked_supply,
  input wire logic print_active,
  input wire logic sheet_in_fuser,
  input wire logic sleep_cmd,
  input wire logic wake_cmd,
  output logic heater_drive,
  output logic relay_enable_request,
  output logic main_relay_drive,
  output logic sub_relay_drive,
  output logic fuser_motor_enable,
  output logic [1:0] engine_speed,
  output logic supply_off,
  output logic power_save_request,
  output logic cover_open,
  output logic irq
);
  import fuser_pkg::*;

  function automatic logic [13:0] media_entry(input logic [MEDIA_W-1:0] idx);
    logic [13:0] e;
    unique case (idx)
      5'd6, 5'd11, 5'd12, 5'd15, 5'd16, 5'd20: e = {SPEED_HALF, 12'h708};
      5'd4, 5'd18, 5'd19: e = {SPEED_THIRD, 12'h708};
      5'd10: e = {SPEED_FULL, 12'h6d6};
      5'd13, 5'd14: e = {SPEED_HALF, 12'h6a4};
      5'd17: e = {SPEED_THIRD, 12'h672};
      5'd0, 5'd1: e = {SPEED_AUTO, 12'h000};
      default: e = {SPEED_FULL, 12'h79e};
    endcase
    return e;
  endfunction

  logic tick;
  logic safety_fail;
  fuser_state_t state_q;
  logic enable_q;
  logic [MEDIA_W-1:0] media_q;
  logic [11:0] auto_target_q;
  logic [7:0] gap_drop_q;
  logic [INT_W-1:0] int_status_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] int_event;
  logic ctrl_fail_q;
  logic heat_off_q;
  logic cover_q;
  logic mains_100_q;
  logic [15:0] timer_ms_q;
  logic [15:0] since_print_q;
  logic [15:0] step_ms_q;
  logic [7:0] step_q;
  logic [5:0] count_q;
  logic sheet_q;
  logic [11:0] ramp_mv_q;
  logic [4:0] startup_duty_q;
  logic [3:0] pwm_q;
  logic heat_want_q;
  logic ctrl_trip;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [13:0] media_e;
  logic [11:0] print_t10;
  logic [11:0] target_t10;
  logic [11:0] target_mv;
  logic [11:0] hyst_mv;
  logic [4:0] duty;
  logic [4:0] duty_cap;
  logic warm_start;
  logic cold_power_on;

  ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  relay_safety u_safety (
    .pclk(pclk),
    .presetn(presetn),
    .main_temp_sense(main_temp_sense),
    .sub_temp_sense(sub_temp_sense),
    .relay_enable_request(relay_enable_request),
    .main_relay_drive(main_relay_drive),
    .sub_relay_drive(sub_relay_drive),
    .safety_fail(safety_fail)
  );

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign addr_ok = (paddr == CTRL_OFS) || (paddr == AUTO_TARGET_OFS) || (paddr == GAP_DROP_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == INT_STATUS_OFS) || (paddr == INT_MASK_OFS);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      media_q <= '0;
      auto_target_q <= AUTO_TARGET_RST;
      gap_drop_q <= GAP_DROP_RST;
      int_mask_q <= '0;
    end else if (wr_en) begin
      if (paddr == CTRL_OFS && pstrb[0]) begin
        enable_q <= pwdata[CTRL_ENABLE_BIT];
        media_q <= pwdata[CTRL_MEDIA_LSB +: MEDIA_W];
      end
      if (paddr == AUTO_TARGET_OFS && pstrb[0]) begin
        auto_target_q[7:0] <= pwdata[7:0];
      end
      if (paddr == AUTO_TARGET_OFS && pstrb[1]) begin
        auto_target_q[11:8] <= pwdata[11:8];
      end
      if (paddr == GAP_DROP_OFS && pstrb[0]) begin
        gap_drop_q <= pwdata[7:0];
      end
      if (paddr == INT_MASK_OFS && pstrb[0]) begin
        int_mask_q <= pwdata[INT_W-1:0];
      end
    end
  end

  // Read data is registered in the setup cycle so it is stable through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      unique case (paddr)
        CTRL_OFS: prdata <= {26'h0, media_q, enable_q};
        AUTO_TARGET_OFS: prdata <= {20'h0, auto_target_q};
        GAP_DROP_OFS: prdata <= {24'h0, gap_drop_q};
        STATUS_OFS: prdata <= {16'h0, main_relay_drive, sub_relay_drive, relay_enable_request, heater_drive,
                               safety_fail, ctrl_fail_q, cover_q, mains_100_q, engine_speed, power_save_request,
                               fuser_motor_enable, 1'b0, state_q};
        INT_STATUS_OFS: prdata <= {27'h0, int_status_q};
        INT_MASK_OFS: prdata <= {27'h0, int_mask_q};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_q <= '0;
    end else begin
      int_status_q <= (int_status_q & ~((wr_en && paddr == INT_STATUS_OFS && pstrb[0]) ?
                      pwdata[INT_W-1:0] : '0)) | int_event;
    end
  end
  assign irq = |(int_status_q & int_mask_q);

  assign int_event[INT_CTRL_FAIL] = ctrl_trip && !ctrl_fail_q;
  assign int_event[INT_SAFETY_FAIL] = safety_fail && !(state_q == ST_FAIL);
  assign int_event[INT_COVER_OPEN] = !interlocked_supply && !cover_q;
  assign int_event[INT_SLEEP] = (state_q == ST_STANDBY || state_q == ST_IDLE) && sleep_cmd;
  assign int_event[INT_WAKE] = (state_q == ST_SLEEP) && wake_cmd;

  assign ctrl_trip = (main_temp_sense <= CTRL_MAIN_FAIL_MV) || (sub_temp_sense >= CTRL_SUB_FAIL_MV);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cover_q <= 1'b0;
      mains_100_q <= 1'b0;
    end else begin
      cover_q <= !interlocked_supply;
      mains_100_q <= low_mains_detect;
    end
  end
  assign cover_open = cover_q;

  // Heater drive goes low the cycle the fault is latched; the relay request follows one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_fail_q <= 1'b0;
      heat_off_q <= 1'b0;
    end else begin
      if (ctrl_trip || safety_fail) begin
        ctrl_fail_q <= 1'b1;
      end
      heat_off_q <= ctrl_fail_q;
    end
  end
  assign relay_enable_request = !heat_off_q && (state_q != ST_SLEEP);

  assign cold_power_on = sub_temp_sense < sub_mv_of(COLD_SUB_T10);
  assign warm_start = since_print_q < 16'(WARM_WINDOW_MS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else if (ctrl_fail_q) begin
      state_q <= ST_FAIL;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sleep_cmd) begin
            state_q <= ST_SLEEP;
          end else if (enable_q) begin
            state_q <= cold_power_on ? ST_INIT_HEAT : ST_STARTUP;
          end
        end
        ST_INIT_HEAT: begin
          if (!enable_q) begin
            state_q <= ST_IDLE;
          end else if (timer_ms_q >= 16'(INIT_HEAT_MS)) begin
            state_q <= ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (!enable_q) begin
            state_q <= ST_IDLE;
          end else if (ramp_mv_q <= main_mv_of(STANDBY_T10) && main_temp_sense <= main_mv_of(STANDBY_T10)) begin
            state_q <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!enable_q) begin
            state_q <= ST_IDLE;
          end else if (sleep_cmd) begin
            state_q <= ST_SLEEP;
          end else if (print_active && !cover_q) begin
            state_q <= ST_PRINT;
          end
        end
        ST_PRINT: begin
          if (!enable_q) begin
            state_q <= ST_IDLE;
          end else if (!print_active || cover_q) begin
            state_q <= ST_STANDBY;
          end
        end
        ST_SLEEP: begin
          if (wake_cmd) begin
            state_q <= enable_q ? ST_STARTUP : ST_IDLE;
          end
        end
        ST_FAIL: state_q <= ST_FAIL;
      endcase
    end
  end

  assign supply_off = (state_q == ST_SLEEP);
  assign power_save_request = (state_q == ST_SLEEP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ms_q <= 16'h0;
      since_print_q <= 16'(WARM_WINDOW_MS);
    end else begin
      if (state_q != ST_INIT_HEAT) begin
        timer_ms_q <= 16'h0;
      end else if (tick) begin
        timer_ms_q <= timer_ms_q + 16'h1;
      end
      if (state_q == ST_PRINT) begin
        since_print_q <= 16'h0;
      end else if (tick && since_print_q < 16'(WARM_WINDOW_MS)) begin
        since_print_q <= since_print_q + 16'h1;
      end
    end
  end

  // Start-up power and starting point are latched at energisation, then the ramp walks toward standby.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_duty_q <= DUTY_FULL;
      ramp_mv_q <= 12'h0;
    end else if (state_q != ST_STARTUP) begin
      startup_duty_q <= (sub_temp_sense >= sub_mv_of(WARM_SUB_T10)) ? DUTY_WARM : DUTY_FULL;
      ramp_mv_q <= warm_start ? main_temp_sense : main_mv_of(COLD_START_T10);
    end else if (tick && ramp_mv_q > main_mv_of(STANDBY_T10) + RAMP_MV_PER_MS) begin
      ramp_mv_q <= ramp_mv_q - RAMP_MV_PER_MS;
    end else if (tick) begin
      ramp_mv_q <= main_mv_of(STANDBY_T10);
    end
  end

  // Within a print the target climbs in steps; each finished sheet up to the 40th adds to the continuous count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_ms_q <= 16'h0;
      step_q <= 8'h0;
      count_q <= 6'h0;
      sheet_q <= 1'b0;
    end else begin
      sheet_q <= sheet_in_fuser;
      if (state_q != ST_PRINT) begin
        step_ms_q <= 16'h0;
        step_q <= 8'h0;
        count_q <= 6'h0;
      end else begin
        if (!sheet_in_fuser) begin
          step_ms_q <= 16'h0;
          step_q <= 8'h0;
        end else if (tick && step_ms_q >= 16'(STEP_MS - 1)) begin
          step_ms_q <= 16'h0;
          step_q <= (step_q < STEP_MAX_T10) ? step_q + STEP_T10 : step_q;
        end else if (tick) begin
          step_ms_q <= step_ms_q + 16'h1;
        end
        if (sheet_q && !sheet_in_fuser && count_q < COUNT_MAX) begin
          count_q <= count_q + 6'h1;
        end
      end
    end
  end

  assign media_e = media_entry(media_q);
  assign engine_speed = media_e[13:12];
  // Every fourth continuous sheet up to the 40th trims one degree, since the roller holds more heat over a run.
  assign print_t10 = ((media_e[11:0] == 12'h0) ? auto_target_q : media_e[11:0]) + 12'(step_q) -
                     12'({count_q[5:2], 3'h0}) - 12'({count_q[5:2], 1'h0});

  always_comb begin
    target_t10 = STANDBY_T10;
    if (state_q == ST_PRINT) begin
      target_t10 = sheet_in_fuser ? print_t10 : print_t10 - 12'(gap_drop_q);
    end
  end

  assign target_mv = (state_q == ST_STARTUP && ramp_mv_q > main_mv_of(target_t10)) ? ramp_mv_q :
                     main_mv_of(target_t10);
  assign hyst_mv = mains_100_q ? HYST_100_MV : HYST_200_MV;
  assign duty_cap = mains_100_q ? DUTY_FULL : DUTY_200_CAP;
  assign duty = (state_q == ST_STARTUP && startup_duty_q < duty_cap) ? startup_duty_q : duty_cap;

  // Main sense falls as it heats, so a voltage above the target band means the sleeve is cold.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_want_q <= 1'b0;
      pwm_q <= 4'h0;
    end else begin
      if (tick) begin
        pwm_q <= pwm_q + 4'h1;
      end
      if ({1'b0, main_temp_sense} > {1'b0, target_mv} + {1'b0, hyst_mv}) begin
        heat_want_q <= 1'b1;
      end else if ({1'b0, main_temp_sense} + {1'b0, hyst_mv} < {1'b0, target_mv}) begin
        heat_want_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heater_drive <= 1'b0;
    end else if (ctrl_trip || ctrl_fail_q || safety_fail) begin
      heater_drive <= 1'b0;
    end else if (state_q == ST_INIT_HEAT) begin
      heater_drive <= 1'b1;
    end else if (state_q == ST_STARTUP || state_q == ST_STANDBY || state_q == ST_PRINT) begin
      heater_drive <= heat_want_q && ({1'b0, pwm_q} < duty);
    end else begin
      heater_drive <= 1'b0;
    end
  end

  assign fuser_motor_enable = (state_q == ST_STARTUP || state_q == ST_STANDBY || state_q == ST_PRINT) &&
                              !cover_q;
endmodule

/* File: verif/fuser_checker.sv */
// Concurrent checks on the fuser controller ports.
// Assumes one pclk domain and is bound onto every fuser_ctrl instance.
`timescale 1ns/100ps
module fuser_checker import fuser_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] main_temp_sense,
  input wire logic [11:0] sub_temp_sense,
  input wire logic interlocked_supply,
  input wire logic heater_drive,
  input wire logic relay_enable_request,
  input wire logic main_relay_drive,
  input wire logic sub_relay_drive,
  input wire logic [1:0] engine_speed,
  input wire logic supply_off,
  input wire logic power_save_request,
  input wire logic cover_open
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire ct = main_temp_sense <= CTRL_MAIN_FAIL_MV || sub_temp_sense >= CTRL_SUB_FAIL_MV;
  wire st = main_temp_sense <= SAFE_MAIN_FAIL_MV || sub_temp_sense >= SAFE_SUB_FAIL_MV;
  property p_trip; ct |=> !heater_drive [*8]; endproperty
  a_trip: assert property (p_trip) else $error("heater on after trip");
  property p_req; $rose(ct) && relay_enable_request |=> relay_enable_request && !heater_drive; endproperty
  a_req: assert property (p_req) else $error("heater and relay request out of order");
  property p_order; ct |-> ##2 !relay_enable_request ##1 !main_relay_drive ##1 !sub_relay_drive; endproperty
  a_order: assert property (p_order) else $error("relay release late");
  property p_safe; st |=> !main_relay_drive; endproperty
  a_safe: assert property (p_safe) else $error("safety trip missed");
  property p_seq; $fell(sub_relay_drive) |-> $past(!main_relay_drive); endproperty
  a_seq: assert property (p_seq) else $error("sub relay opened before main");
  property p_cover; !interlocked_supply |=> cover_open; endproperty
  a_cover: assert property (p_cover) else $error("cover open missed");
  property p_sleep; power_save_request == supply_off; endproperty
  a_sleep: assert property (p_sleep) else $error("power save and supply off differ");
  property p_speed; !(psel && penable && pwrite) |=> $stable(engine_speed); endproperty
  a_speed: assert property (p_speed) else $error("speed moved without write");
endmodule
bind fuser_ctrl fuser_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .main_temp_sense,
  .sub_temp_sense, .interlocked_supply, .heater_drive, .relay_enable_request, .main_relay_drive,
  .sub_relay_drive, .engine_speed, .supply_off, .power_save_request, .cover_open);

/* File: verif/heater_plant.sv */
// Thermal model of heater and thermistors feeding the sense inputs.
// Assumes the bench forces a sense code to inject a fault, zero meaning none.
`timescale 1ns/100ps
module heater_plant (
  input wire logic pclk,
  input wire logic heater_drive,
  input wire logic [11:0] main_force,
  input wire logic [11:0] sub_force,
  output logic [11:0] main_temp_sense,
  output logic [11:0] sub_temp_sense
);
  int t10 = 250;
  // Capped well below any trip point, so only a forced code can fail the fuser.
  always @(posedge pclk) begin
    if (heater_drive && t10 < 2000) begin
      t10 <= t10 + 1;
    end else if (!heater_drive && t10 > 250) begin
      t10 <= t10 - 1;
    end
  end
  assign main_temp_sense = (main_force != 12'h000) ? main_force : 12'(3000 - t10 * 913 / 1000);
  assign sub_temp_sense = (sub_force != 12'h000) ? sub_force : 12'(t10 * 161 / 1000);
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the fuser controller over APB with a thermal plant.
// Assumes shortened timers and the checker bound onto the design.
`timescale 1ns/100ps
module tb;
  import fuser_pkg::*;
  localparam logic [41:0] SPEED_TABLE = 42'h2feaa956750;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, irq;
  logic low_mains_detect, interlocked_supply, sleep_cmd, wake_cmd, cover_open;
  logic heater_drive, relay_enable_request, main_relay_drive, sub_relay_drive;
  logic fuser_motor_enable, supply_off, power_save_request, print_active, sheet_in_fuser;
  logic [1:0] engine_speed;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [11:0] main_force, sub_force, main_temp_sense, sub_temp_sense;
  int comparisons = 0;
  int miscompares = 0;
  heater_plant plant_u (.pclk, .heater_drive, .main_force, .sub_force, .main_temp_sense, .sub_temp_sense);
  fuser_ctrl #(.TICK_CYCLES(10), .WARM_WINDOW_MS(50), .INIT_HEAT_MS(5), .STEP_MS(3)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .main_temp_sense, .sub_temp_sense, .low_mains_detect, .interlocked_supply, .print_active,
    .sheet_in_fuser, .sleep_cmd, .wake_cmd, .heater_drive, .relay_enable_request, .main_relay_drive,
    .sub_relay_drive, .fuser_motor_enable, .engine_speed, .supply_off, .power_save_request, .cover_open, .irq);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_cmd, wake_cmd, print_active, sheet_in_fuser} = '0;
    {paddr, pwdata, main_force, sub_force} = '0;
    {low_mains_detect, interlocked_supply} = 2'h3;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, AUTO_TARGET_OFS, 0);
    chk(rdat, 32'h76c);
    apb(0, GAP_DROP_OFS, 0);
    chk(rdat, 32'h64);
    apb(0, 8'h40, 0);
    chk(serr, 1);
    $display("test registers done");
    for (int i = 0; i < 21; i++) begin
      apb(1, CTRL_OFS, 32'(i) << 1);
      @(negedge pclk);
      chk(engine_speed, SPEED_TABLE[2*i +: 2]);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      low_mains_detect <= m[0];
      repeat (4) @(posedge pclk);
      apb(0, STATUS_OFS, 0);
      chk(rdat[8], m[0]);
    end
    $display("test media and mains done");
    apb(1, INT_MASK_OFS, 32'h1f);
    interlocked_supply <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(cover_open, 1);
    @(posedge pclk);
    interlocked_supply <= 1'b1;
    apb(0, INT_STATUS_OFS, 0);
    chk(rdat[INT_COVER_OPEN], 1);
    apb(1, INT_MASK_OFS, 0);
    @(negedge pclk);
    chk(irq, 0);
    apb(1, INT_MASK_OFS, 32'h1f);
    @(negedge pclk);
    chk(irq, 1);
    apb(1, INT_STATUS_OFS, 32'h1f);
    @(negedge pclk);
    chk(irq, 0);
    $display("test cover and interrupt done");
    @(posedge pclk);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    @(negedge pclk);
    chk({supply_off, power_save_request}, 2'h3);
    apb(0, STATUS_OFS, 0);
    chk(rdat[2:0], 5);
    wake_cmd <= 1'b1;
    @(posedge pclk);
    wake_cmd <= 1'b0;
    apb(0, STATUS_OFS, 0);
    chk(rdat[2:0], 0);
    chk(rdat[5], 0);
    apb(0, INT_STATUS_OFS, 0);
    chk(rdat[4:3], 2'h3);
    $display("test sleep done");
    apb(1, CTRL_OFS, 32'h1);
    apb(0, STATUS_OFS, 0);
    chk(rdat[2:0], 1);
    chk(rdat[4], 0);
    for (int k = 0; k < 3000 && rdat[2:0] !== 3'h3; k++) begin
      apb(0, STATUS_OFS, 0);
    end
    chk(rdat[2:0], 3);
    print_active <= 1'b1;
    sheet_in_fuser <= 1'b1;
    apb(0, STATUS_OFS, 0);
    chk(rdat[2:0], 4);
    print_active <= 1'b0;
    sheet_in_fuser <= 1'b0;
    $display("test warm up done");
    main_force <= 12'h352;
    repeat (6) @(posedge pclk);
    main_force <= 12'h000;
    @(negedge pclk);
    chk({heater_drive, relay_enable_request, main_relay_drive, sub_relay_drive}, 0);
    apb(0, STATUS_OFS, 0);
    chk(rdat[11:10], 1);
    chk(rdat[2:0], 6);
    $display("test controller trip done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({main_relay_drive, sub_relay_drive}, 2'h3);
    @(posedge pclk);
    sub_force <= 12'h1a4;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({main_relay_drive, sub_relay_drive}, 0);
    apb(0, STATUS_OFS, 0);
    chk(rdat[11], 1);
    $display("test safety trip done");
    tally_and_finish();
  end
endmodule
